// *** hdl/crm_monitor.sv ***
`include "crm_consts.svh"

module crm_monitor
   import crm_pkg::*;
#(
   parameter int CNT_W = 24
) (
   input  wire logic             clk_sys,
   input  wire logic             reset,
   input  wire logic             clkEn,
   // apb slave
   input  wire logic             psel,
   input  wire logic             penable,
   input  wire logic             pwrite,
   input  wire logic [7:0]       paddr,
   input  wire logic [31:0]      pwdata,
   output logic      [31:0]      prdata,
   output logic                  pready,
   output logic                  pslverr,
   // serial control port
   input  wire logic             spiCs_n,
   input  wire logic             spiSck,
   input  wire logic             spiMosi,
   output logic                  spiMiso,
   // reference clocks and coax output
   input  wire logic             localRefClk,
   input  wire logic             extRefClk,
   output logic                  refOut,
   // status pins
   output logic                  localRefInRange,
   output logic                  externalRefInRange
);

   // control registers
   logic             refOutputSelect_reg;
   logic             counterClearCtl_reg;
   logic [CNT_W-1:0] lower_reg;
   logic [CNT_W-1:0] upper_reg;
   logic [CNT_W-1:0] term_reg;
   // shadows in use by the running window
   logic [CNT_W-1:0] lowerSh_reg;
   logic [CNT_W-1:0] upperSh_reg;
   logic [CNT_W-1:0] termSh_reg;
   // measurement state
   logic [CNT_W-1:0] winCnt_reg;
   logic [1:0]       inRange_reg;
   logic             refOut_reg;

   // serial port state
   crm_spi_state_t   spiState_reg;
   crm_spi_state_t   spiState_next;
   logic [4:0]       spiBit_reg;
   logic [3:0]       spiHdr_reg;
   logic [23:0]      spiShift_reg;
   logic             spiMiso_reg;
   logic [2:0]       sckSync_reg;
   logic [1:0]       csSync_reg;
   logic [1:0]       mosiSync_reg;

   // ------------------------------------------------------------------
   // apb decode
   // ------------------------------------------------------------------
   logic        apbAccess;
   logic        apbWr;
   logic        apbHitCtrl;
   logic        apbHitLower;
   logic        apbHitUpper;
   logic        apbHitTerm;
   logic        apbHit;
   logic [31:0] apbRdata;

   assign apbAccess   = psel & penable;
   assign apbWr       = apbAccess & pwrite & clkEn;
   assign apbHitCtrl  = (paddr == `CRM_OFS_CTRL);
   assign apbHitLower = (paddr == `CRM_OFS_LOWER);
   assign apbHitUpper = (paddr == `CRM_OFS_UPPER);
   assign apbHitTerm  = (paddr == `CRM_OFS_TERM);
   assign apbHit      = apbHitCtrl | apbHitLower | apbHitUpper | apbHitTerm;

   // zero-wait slave; unmapped offsets answer with an error
   assign pready  = 1'b1;
   assign pslverr = apbAccess & ~apbHit;
   assign prdata  = (apbAccess & ~pwrite) ? apbRdata : 32'h00000000;

   // ------------------------------------------------------------------
   // shared read view of every register
   // ------------------------------------------------------------------
   logic [31:0] ctrlView;
   logic [31:0] lowerView;
   logic [31:0] upperView;
   logic [31:0] termView;

   always_comb begin
      ctrlView                 = 32'h00000000;
      ctrlView[`CRM_BIT_SEL]   = refOutputSelect_reg;
      ctrlView[`CRM_BIT_CLR]   = counterClearCtl_reg;
      ctrlView[`CRM_BIT_LOCOK] = inRange_reg[0];
      ctrlView[`CRM_BIT_EXTOK] = inRange_reg[1];
   end

   assign lowerView = {{(32-CNT_W){1'b0}}, lower_reg};
   assign upperView = {{(32-CNT_W){1'b0}}, upper_reg};
   assign termView  = {{(32-CNT_W){1'b0}}, term_reg};

   assign apbRdata = apbHitCtrl  ? ctrlView  :
                     apbHitLower ? lowerView :
                     apbHitUpper ? upperView :
                     apbHitTerm  ? termView  : 32'h00000000;

   // ------------------------------------------------------------------
   // serial port: pins synchronised, then sampled at 100 MHz
   // ------------------------------------------------------------------
   // two-stage synchronisers; third sck stage only for edge detection
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         sckSync_reg  <= 3'h0;
         csSync_reg   <= 2'h3;
         mosiSync_reg <= 2'h0;
      end else if (clkEn) begin
         sckSync_reg  <= {sckSync_reg[1:0], spiSck};
         csSync_reg   <= {csSync_reg[0], spiCs_n};
         mosiSync_reg <= {mosiSync_reg[0], spiMosi};
      end
   end

   logic       sckRise;
   logic       sckFall;
   logic       csIdle;
   logic       mosiBit;
   logic       spiIsRead;
   logic [2:0] spiAddr;
   logic       spiHdrDone;
   logic       spiLastBit;
   logic       spiWr;
   logic [23:0] spiWdata;
   logic [31:0] spiRdata;

   assign sckRise    = sckSync_reg[1] & ~sckSync_reg[2];
   assign sckFall    = ~sckSync_reg[1] & sckSync_reg[2];
   assign csIdle     = csSync_reg[1];
   assign mosiBit    = mosiSync_reg[1];
   assign spiIsRead  = spiHdr_reg[3];
   assign spiAddr    = {spiHdr_reg[1:0], mosiBit};
   assign spiHdrDone = (spiState_reg == CRM_SPI_HDR) & sckRise &
                       (spiBit_reg == `CRM_SPI_HDR_LAST);
   assign spiLastBit = (spiState_reg == CRM_SPI_DATA) & sckRise &
                       (spiBit_reg == `CRM_SPI_LAST);
   assign spiWdata   = {spiShift_reg[22:0], mosiBit};
   assign spiWr      = spiLastBit & ~spiIsRead & ~csIdle & clkEn;

   // read data picked at the end of the header
   assign spiRdata = (spiAddr == `CRM_IDX_CTRL)  ? ctrlView  :
                     (spiAddr == `CRM_IDX_LOWER) ? lowerView :
                     (spiAddr == `CRM_IDX_UPPER) ? upperView :
                     (spiAddr == `CRM_IDX_TERM)  ? termView  : 32'h00000000;

   // frame sequencing; extra clocks after a full frame are dropped
   always_comb begin
      spiState_next = spiState_reg;
      case (spiState_reg)
         CRM_SPI_IDLE: begin
            if (!csIdle) begin
               spiState_next = CRM_SPI_HDR;
            end
         end
         CRM_SPI_HDR: begin
            if (spiHdrDone) begin
               spiState_next = CRM_SPI_DATA;
            end
         end
         CRM_SPI_DATA: begin
            if (spiLastBit) begin
               spiState_next = CRM_SPI_DONE;
            end
         end
         CRM_SPI_DONE: begin
            spiState_next = CRM_SPI_DONE;
         end
         default: begin
            spiState_next = CRM_SPI_IDLE;
         end
      endcase
      if (csIdle) begin
         spiState_next = CRM_SPI_IDLE;
      end
   end

   // state and bit counter
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         spiState_reg <= CRM_SPI_IDLE;
         spiBit_reg   <= 5'h00;
      end else if (clkEn) begin
         spiState_reg <= spiState_next;
         if (csIdle) begin
            spiBit_reg <= 5'h00;
         end else if (sckRise && spiState_reg != CRM_SPI_DONE) begin
            spiBit_reg <= spiBit_reg + 5'h01;
         end
      end
   end

   // header capture and data shifter on the rising edge, miso launch on the falling edge
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         spiHdr_reg   <= 4'h0;
         spiShift_reg <= 24'h000000;
         spiMiso_reg  <= 1'b0;
      end else if (clkEn) begin
         if (spiState_reg == CRM_SPI_HDR && sckRise) begin
            spiHdr_reg <= {spiHdr_reg[2:0], mosiBit};
         end
         if (spiHdrDone) begin
            spiShift_reg <= spiRdata[23:0];
         end else if (spiState_reg == CRM_SPI_DATA && sckRise) begin
            spiShift_reg <= spiWdata;
         end
         if (sckFall) begin
            spiMiso_reg <= spiShift_reg[23];
         end
      end
   end

   assign spiMiso = spiMiso_reg;

   // ------------------------------------------------------------------
   // register writes from either port
   // ------------------------------------------------------------------
   logic        wrCtrl;
   logic        wrLower;
   logic        wrUpper;
   logic        wrTerm;
   logic [31:0] wrData;
   logic [2:0]  spiHdrAddr;

   // apb data goes to every register written should both ports collide in one cycle
   assign spiHdrAddr = spiHdr_reg[2:0];
   assign wrData  = apbWr ? pwdata : {8'h00, spiWdata};
   assign wrCtrl  = (apbWr & apbHitCtrl)  | (spiWr & (spiHdrAddr == `CRM_IDX_CTRL));
   assign wrLower = (apbWr & apbHitLower) | (spiWr & (spiHdrAddr == `CRM_IDX_LOWER));
   assign wrUpper = (apbWr & apbHitUpper) | (spiWr & (spiHdrAddr == `CRM_IDX_UPPER));
   assign wrTerm  = (apbWr & apbHitTerm)  | (spiWr & (spiHdrAddr == `CRM_IDX_TERM));

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         refOutputSelect_reg <= `CRM_RST_SEL;
         counterClearCtl_reg <= `CRM_RST_CLR;
      end else if (wrCtrl) begin
         refOutputSelect_reg <= wrData[`CRM_BIT_SEL];
         counterClearCtl_reg <= wrData[`CRM_BIT_CLR];
      end
   end

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         lower_reg <= CNT_W'(`CRM_RST_LIMIT);
         upper_reg <= CNT_W'(`CRM_RST_LIMIT);
         term_reg  <= CNT_W'(`CRM_RST_TERM);
      end else begin
         if (wrLower) lower_reg <= wrData[CNT_W-1:0];
         if (wrUpper) upper_reg <= wrData[CNT_W-1:0];
         if (wrTerm)  term_reg  <= wrData[CNT_W-1:0];
      end
   end

   // ------------------------------------------------------------------
   // window timing on the system clock
   // ------------------------------------------------------------------
   logic winEnd;

   assign winEnd = ~counterClearCtl_reg & (winCnt_reg >= termSh_reg);

   // held clear, cleared at end, free running
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         winCnt_reg <= '0;
      end else if (clkEn) begin
         if (counterClearCtl_reg || winEnd) begin
            winCnt_reg <= '0;
         end else begin
            winCnt_reg <= winCnt_reg + CNT_W'(1);
         end
      end
   end

   // shadows reloaded at window end and while the clear bit is set
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         lowerSh_reg <= CNT_W'(`CRM_RST_LIMIT);
         upperSh_reg <= CNT_W'(`CRM_RST_LIMIT);
         termSh_reg  <= CNT_W'(`CRM_RST_TERM);
      end else if (clkEn && (winEnd || counterClearCtl_reg)) begin
         lowerSh_reg <= lower_reg;
         upperSh_reg <= upper_reg;
         termSh_reg  <= term_reg;
      end
   end

   // ------------------------------------------------------------------
   // per-reference edge counters and checks
   // ------------------------------------------------------------------
   logic [1:0] refPin;
   logic [1:0] refSync;

   assign refPin = {extRefClk, localRefClk};

   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_ref
         logic [2:0]       sync_reg;
         logic [CNT_W-1:0] cnt_reg;
         logic             rise;
         logic             pass;

         always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
               sync_reg <= 3'h0;
            end else if (clkEn) begin
               sync_reg <= {sync_reg[1:0], refPin[g]};
            end
         end

         assign rise       = sync_reg[1] & ~sync_reg[2];
         assign refSync[g] = sync_reg[1];

         always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
               cnt_reg <= '0;
            end else if (clkEn) begin
               if (counterClearCtl_reg || winEnd) begin
                  cnt_reg <= '0;
               end else if (rise) begin
                  cnt_reg <= cnt_reg + CNT_W'(1);
               end
            end
         end

         assign pass = (cnt_reg > lowerSh_reg) & (cnt_reg < upperSh_reg);

         always_ff @(posedge clk_sys or posedge reset) begin
            if (reset) begin
               inRange_reg[g] <= 1'b0;
            end else if (clkEn && winEnd) begin
               inRange_reg[g] <= pass;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         refOut_reg <= 1'b0;
      end else if (clkEn) begin
         refOut_reg <= refOutputSelect_reg ? refSync[1] : refSync[0];
      end
   end

   assign refOut             = refOut_reg;
   assign localRefInRange    = inRange_reg[0];
   assign externalRefInRange = inRange_reg[1];

endmodule : crm_monitor

// *** hdl/crm_consts.svh ***
`ifndef CRM_CONSTS_SVH
`define CRM_CONSTS_SVH

// clock figures
`define CRM_CLK_MHZ        100
`define CRM_OSC_MHZ        50
// register byte offsets
`define CRM_OFS_CTRL       8'h00
`define CRM_OFS_LOWER      8'h08
`define CRM_OFS_UPPER      8'h0c
`define CRM_OFS_TERM       8'h10
// register indices on the serial port
`define CRM_IDX_CTRL       3'h0
`define CRM_IDX_LOWER      3'h2
`define CRM_IDX_UPPER      3'h3
`define CRM_IDX_TERM       3'h4
// control and status bit positions
`define CRM_BIT_SEL        10
`define CRM_BIT_CLR        7
`define CRM_BIT_LOCOK      5
`define CRM_BIT_EXTOK      4
// reset values
`define CRM_RST_SEL        1'h0
`define CRM_RST_CLR        1'h0
`define CRM_RST_LIMIT      24'h000000
`define CRM_RST_TERM       24'h000000
// serial frame: read/write bit, three address bits, 24 data bits
`define CRM_SPI_HDR_LAST   5'h03
`define CRM_SPI_LAST       5'h1b
`endif

// *** hdl/crm_pkg.sv ***
package crm_pkg;

   // serial port frame states
   typedef enum logic [1:0] {
      CRM_SPI_IDLE = 2'b00,
      CRM_SPI_HDR  = 2'b01,
      CRM_SPI_DATA = 2'b10,
      CRM_SPI_DONE = 2'b11
   } crm_spi_state_t;

endpackage : crm_pkg

// *** test/crm_monitor_assertions.sv ***
`include "crm_consts.svh"

module crm_monitor_assertions
   import crm_pkg::*;
#(
   parameter int CNT_W = 24
) (
   input wire logic        clk_sys,
   input wire logic        reset,
   input wire logic        clkEn,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic        spiCs_n,
   input wire logic        spiSck,
   input wire logic        spiMosi,
   input wire logic        spiMiso,
   input wire logic        localRefClk,
   input wire logic        extRefClk,
   input wire logic        refOut,
   input wire logic        localRefInRange,
   input wire logic        externalRefInRange
);
   logic       selMirror_reg;
   logic       clrMirror_reg;
   logic [2:0] sinceRst_reg;
   logic [2:0] sinceSel_reg;

   // decode of apb accesses seen at the pins
   wire isCtrl = (paddr == `CRM_OFS_CTRL);
   wire isWord = (paddr == `CRM_OFS_LOWER) || (paddr == `CRM_OFS_UPPER)
                 || (paddr == `CRM_OFS_TERM);
   wire ctrlWr = psel && penable && pready && pwrite && clkEn && isCtrl;
   wire rdAcc  = psel && penable && !pwrite;

   // mirror of apb control writes, cycles since reset and since a select change
   always_ff @(posedge clk_sys or posedge reset) begin
      if (reset) begin
         selMirror_reg <= 1'h0;
         clrMirror_reg <= 1'h0;
         sinceRst_reg  <= 3'h0;
         sinceSel_reg  <= 3'h7;
      end else begin
         if (ctrlWr) selMirror_reg <= pwdata[`CRM_BIT_SEL];
         if (ctrlWr) clrMirror_reg <= pwdata[`CRM_BIT_CLR];
         if (sinceRst_reg != 3'h7) sinceRst_reg <= sinceRst_reg + 3'h1;
         if (ctrlWr && (pwdata[`CRM_BIT_SEL] != selMirror_reg)) sinceSel_reg <= 3'h0;
         else if (sinceSel_reg != 3'h7) sinceSel_reg <= sinceSel_reg + 3'h1;
      end
   end

   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (reset);

   ready_high_a: assert property (pready)
      else $error("pready low");
   unmapped_err_a: assert property (psel && penable && !(isCtrl || isWord) |-> pslverr)
      else $error("no error on unmapped access");
   mapped_ok_a: assert property (psel && penable && (isCtrl || isWord) |-> !pslverr)
      else $error("error on mapped access");
   rdata_idle_a: assert property (!rdAcc |-> prdata == 32'h0)
      else $error("read data outside read access");
   ctrl_layout_a: assert property (rdAcc && isCtrl |-> prdata[`CRM_BIT_SEL] == selMirror_reg
      && prdata[`CRM_BIT_CLR] == clrMirror_reg && (prdata & 32'hfffffb4f) == 32'h0)
      else $error("control read back wrong");
   status_bits_a: assert property (rdAcc && isCtrl |-> prdata[`CRM_BIT_LOCOK] ==
      localRefInRange && prdata[`CRM_BIT_EXTOK] == externalRefInRange)
      else $error("status bits differ from pins");
   word_width_a: assert property (rdAcc && isWord |-> (prdata >> CNT_W) == 32'h0)
      else $error("limit word upper bits set");
   clear_holds_a: assert property (clrMirror_reg && $past(clrMirror_reg)
      && $past(clrMirror_reg, 2) |-> $stable(localRefInRange) && $stable(externalRefInRange))
      else $error("flag moved while counters cleared");
   refout_select_a: assert property (sinceRst_reg == 3'h7 && sinceSel_reg >= 3'h5
      && $past(clkEn) && $past(clkEn, 2) && $past(clkEn, 3)
      |-> refOut == (selMirror_reg ? $past(extRefClk, 3) : $past(localRefClk, 3)))
      else $error("coax output not the selected reference");
endmodule : crm_monitor_assertions

bind crm_monitor crm_monitor_assertions #(.CNT_W(CNT_W)) crm_monitor_assertions_i (
   .clk_sys(clk_sys), .reset(reset), .clkEn(clkEn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
   .pslverr(pslverr), .spiCs_n(spiCs_n), .spiSck(spiSck), .spiMosi(spiMosi),
   .spiMiso(spiMiso), .localRefClk(localRefClk), .extRefClk(extRefClk), .refOut(refOut),
   .localRefInRange(localRefInRange), .externalRefInRange(externalRefInRange));

// *** test/crm_spi_host.sv ***
module crm_spi_host #(
   parameter int HALF = 6
) (
   input  wire logic clk_sys,
   input  wire logic spiMiso,
   output logic      spiCs_n,
   output logic      spiSck,
   output logic      spiMosi
);
   timeunit 1ns;
   timeprecision 100ps;

   // idle: deselected, mode 0 clock low
   initial begin
      spiCs_n = 1'h1;
      spiSck  = 1'h0;
      spiMosi = 1'h1;
   end

   task automatic frame(input logic rw, input logic [2:0] idx, input logic [23:0] d,
                        input int nbits, output logic [23:0] rd);
      logic [27:0] sh;
      sh = {rw, idx, d};
      rd = 24'h0;
      spiCs_n <= 1'h0;
      repeat (HALF) @(posedge clk_sys);
      for (int i = 0; i < nbits; i++) begin
         spiMosi <= sh[27 - i];
         repeat (HALF) @(posedge clk_sys);
         if (i >= 4) rd = {rd[22:0], spiMiso}; // sampled at the rise
         spiSck <= 1'h1;
         repeat (HALF) @(posedge clk_sys);
         spiSck <= 1'h0;
      end
      repeat (HALF) @(posedge clk_sys);
      spiCs_n <= 1'h1;
      spiMosi <= ~spiMosi; // released line shows no stale bit
      repeat (2 * HALF) @(posedge clk_sys);
   endtask : frame
endmodule : crm_spi_host

// *** test/testbench.sv ***
`include "crm_consts.svh"

module testbench;
   timeunit 1ns;
   timeprecision 100ps;
   localparam int TERM = 199;
   localparam int WIN  = 3 * (TERM + 1) + 20;
   logic        clk_sys, reset, clkEn, psel, penable, pwrite, err;
   logic [7:0]  paddr;
   logic [31:0] pwdata, prdata, rd, flagsW;
   logic        pready, pslverr, spiCs_n, spiSck, spiMosi, spiMiso;
   logic        localRefClk, extRefClk, refOut, localRefInRange, externalRefInRange;
   logic [23:0] srd;
   int          failures, cmp_count, locDiv, extDiv, k;
   logic [2:0]  extDly, locDly;
   // count 20 local and 25 external edges per window
   logic [23:0] loT [4] = '{24'h13, 24'h14, 24'h13, 24'h18};
   logic [23:0] hiT [4] = '{24'h15, 24'h1a, 24'h19, 24'h1a};
   logic [1:0]  expT [4] = '{2'b10, 2'b01, 2'b10, 2'b01};

   assign flagsW = {30'h0, localRefInRange, externalRefInRange};
   always #5 clk_sys = ~clk_sys;

   // local reference 10 cycles a period, external 8
   always @(posedge clk_sys) begin
      locDiv <= (locDiv == 4) ? 0 : locDiv + 1;
      extDiv <= (extDiv == 3) ? 0 : extDiv + 1;
      if (locDiv == 4) localRefClk <= ~localRefClk;
      if (extDiv == 3) extRefClk <= ~extRefClk;
      extDly <= {extDly[1:0], extRefClk};
      locDly <= {locDly[1:0], localRefClk};
   end

   crm_monitor #(.CNT_W(24)) crm_monitor_i (
      .clk_sys(clk_sys), .reset(reset), .clkEn(clkEn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .spiCs_n(spiCs_n), .spiSck(spiSck), .spiMosi(spiMosi),
      .spiMiso(spiMiso), .localRefClk(localRefClk), .extRefClk(extRefClk),
      .refOut(refOut), .localRefInRange(localRefInRange),
      .externalRefInRange(externalRefInRange));
   crm_spi_host #(.HALF(6)) crm_spi_host_i (
      .clk_sys(clk_sys), .spiMiso(spiMiso), .spiCs_n(spiCs_n), .spiSck(spiSck),
      .spiMosi(spiMosi));

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask : report_and_stop

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : chk

   // one apb transfer: setup, access until pready, then an idle cycle
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      psel <= 1'h1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_sys);
      penable <= 1'h1;
      @(posedge clk_sys);
      while (pready !== 1'h1 && n < 50) begin
         n++;
         @(posedge clk_sys);
      end
      if (n == 50) begin
         failures++;
         report_and_stop();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'h0;
      penable <= 1'h0;
      @(posedge clk_sys);
   endtask : apb

   initial begin
      {clk_sys, psel, penable, pwrite, localRefClk, extRefClk} = 6'h0;
      {reset, clkEn} = 2'h3;
      paddr = 8'h0;
      pwdata = 32'h0;
      locDiv = 0;
      extDiv = 0;
      failures = 0;
      cmp_count = 0;
      repeat (12) @(posedge clk_sys);
      reset <= 1'h0;
      @(posedge clk_sys);
      // reset contents and the unmapped hole at 0x04
      for (k = 0; k < 5; k++) begin
         apb(1'h0, 8'(k * 4), 32'h0);
         chk(rd, 32'h0);
         chk({31'h0, err}, {31'h0, k == 1});
      end
      apb(1'h1, 8'h04, 32'hffffffff);
      chk({31'h0, err}, 32'h1);
      // terminal count over spi, lower limit over apb, each read on the other port
      crm_spi_host_i.frame(1'h0, `CRM_IDX_TERM, 24'(TERM), 28, srd);
      apb(1'h0, `CRM_OFS_TERM, 32'h0);
      chk(rd, 32'(TERM));
      apb(1'h1, `CRM_OFS_LOWER, 32'hff000000 | {8'h0, loT[0]});
      crm_spi_host_i.frame(1'h1, `CRM_IDX_LOWER, 24'h0, 28, srd);
      chk({8'h0, srd}, {8'h0, loT[0]});
      apb(1'h0, `CRM_OFS_LOWER, 32'h0);
      chk(rd, {8'h0, loT[0]});
      // an aborted spi frame writes nothing
      crm_spi_host_i.frame(1'h0, `CRM_IDX_UPPER, 24'habcdef, 12, srd);
      apb(1'h0, `CRM_OFS_UPPER, 32'h0);
      chk(rd, 32'h0);
      // limit table with boundary counts; old flags stand right after a change
      for (k = 0; k < 4; k++) begin
         apb(1'h1, `CRM_OFS_LOWER, {8'h0, loT[k]});
         apb(1'h1, `CRM_OFS_UPPER, {8'h0, hiT[k]});
         chk(flagsW, {30'h0, (k == 0) ? 2'b00 : expT[k - 1]});
         repeat (WIN) @(posedge clk_sys);
         chk(flagsW, {30'h0, expT[k]});
         apb(1'h0, `CRM_OFS_CTRL, 32'h0);
         chk(rd, {26'h0, expT[k], 4'h0});
      end
      // clear bit freezes the result, release lets it refresh
      apb(1'h1, `CRM_OFS_CTRL, 32'h80);
      apb(1'h1, `CRM_OFS_LOWER, 32'h0);
      apb(1'h1, `CRM_OFS_UPPER, 32'h1e);
      repeat (WIN) @(posedge clk_sys);
      chk(flagsW, 32'h1);
      apb(1'h0, `CRM_OFS_CTRL, 32'h0);
      chk(rd, 32'h90);
      apb(1'h1, `CRM_OFS_CTRL, 32'h0);
      repeat (WIN) @(posedge clk_sys);
      chk(flagsW, 32'h3);
      // clock enable low blocks a control write
      clkEn <= 1'h0;
      apb(1'h1, `CRM_OFS_CTRL, 32'h400);
      apb(1'h0, `CRM_OFS_CTRL, 32'h0);
      chk(rd, 32'h30);
      clkEn <= 1'h1;
      // coax output switched to the external reference and back
      apb(1'h1, `CRM_OFS_CTRL, 32'h400);
      apb(1'h0, `CRM_OFS_CTRL, 32'h0);
      chk(rd, 32'h430);
      repeat (40) @(posedge clk_sys);
      // coax output follows the pin three clocks late
      for (k = 0; k < 20; k++) begin
         @(negedge clk_sys);
         chk({31'h0, refOut}, {31'h0, extDly[2]});
      end
      @(posedge clk_sys);
      apb(1'h1, `CRM_OFS_CTRL, 32'h0);
      repeat (40) @(posedge clk_sys);
      for (k = 0; k < 20; k++) begin
         @(negedge clk_sys);
         chk({31'h0, refOut}, {31'h0, locDly[2]});
      end
      @(posedge clk_sys);
      report_and_stop();
   end
endmodule : testbench
